// *** hdl/scdp_core.sv ***
// Serial port core: rate divider, data port, master and slave shifting
`timescale 1ns/1ps
module scdp_core #(
   parameter int DIV_W = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire scdp_pkg::scdp_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire scdp_pkg::scdp_cfg_t cfg,
   input wire scdp_pkg::scdp_flags_t flag_clr,
   output scdp_pkg::scdp_flags_t flags,
   output logic tx_buffer_empty_flag,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   input wire logic nss_in,
   output logic sck_out,
   output logic sck_oe,
   output logic mosi_out,
   output logic mosi_oe,
   output logic miso_out,
   output logic miso_oe,
   output logic nss_out,
   output logic nss_oe
);
   scdp_pkg::scdp_core_state_t st_reg;
   scdp_pkg::scdp_core_state_t st_next;
   logic half_end;
   logic s_now;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic shift_edge;
   logic wr_data;
   logic [3:0] half_inc;
   logic [8:0] hc_reg;

   // Divider runs only while a master transfer is in progress
   scdp_half_timer #(.DIV_W(DIV_W)) u_half (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .run(st_reg.mode == scdp_pkg::ST_MASTER),
      .divisor(st_reg.rate),
      .half_end(half_end)
   );

   // External clock normalised so that a rise is always the leading edge
   assign s_now = sck_in ^ cfg.clock_polarity_select;
   assign lead_edge = s_now && !st_reg.s_prev;
   assign trail_edge = !s_now && st_reg.s_prev;
   assign sample_edge = cfg.clock_phase_select ? trail_edge : lead_edge;
   assign shift_edge = cfg.clock_phase_select ? lead_edge : trail_edge;
   assign wr_data = sfr_req.wr && sfr_req.addr == scdp_pkg::ADDR_DATA;
   assign half_inc = st_reg.half + 4'h1;

   always_comb begin
      st_next = st_reg;
      st_next.s_prev = s_now;
      st_next.ss_prev = nss_in;
      st_next.miso = st_reg.osh[7];
      st_next.miso_oe = cfg.enable && !cfg.master && !nss_in;
      // Software clears first so a same-cycle hardware set wins
      if (flag_clr.transfer_done_flag) begin
         st_next.flags.transfer_done_flag = 1'b0;
      end
      if (flag_clr.write_collision_flag) begin
         st_next.flags.write_collision_flag = 1'b0;
      end
      if (flag_clr.mode_fault_flag) begin
         st_next.flags.mode_fault_flag = 1'b0;
      end
      if (sfr_req.wr && sfr_req.addr == scdp_pkg::ADDR_RATE) begin
         st_next.rate = sfr_req.wdata;
      end
      if (wr_data) begin
         if (st_reg.tx_empty) begin
            st_next.txb = sfr_req.wdata;
            st_next.tx_empty = 1'b0;
         end else begin
            st_next.flags.write_collision_flag = 1'b1;
         end
      end
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            scdp_pkg::ADDR_RATE: st_next.rdata = st_reg.rate;
            scdp_pkg::ADDR_DATA: st_next.rdata = st_reg.rxb;
            default: st_next.rdata = scdp_pkg::READ_NONE;
         endcase
      end
      if (cfg.enable && cfg.master && cfg.select_line_mode == scdp_pkg::SEL_MULTI && !nss_in) begin
         st_next.flags.mode_fault_flag = 1'b1;
      end
      // Slave phase-one tail: reload output shifter after the last edge
      if (st_reg.tail_run) begin
         st_next.tail = st_reg.tail + 3'h1;
         if (st_reg.tail == scdp_pkg::TAIL_LAST) begin
            st_next.tail_run = 1'b0;
            st_next.osh = st_reg.tx_empty ? scdp_pkg::DATA_RST : st_reg.txb;
         end
      end
      case (st_reg.mode)
         scdp_pkg::ST_IDLE: begin
            st_next.sck = cfg.clock_polarity_select;
            if (cfg.enable && cfg.master && !st_reg.tx_empty) begin
               st_next.mode = scdp_pkg::ST_MASTER;
               st_next.osh = st_reg.txb;
               st_next.mosi = st_reg.txb[7];
               st_next.tx_empty = 1'b1;
               st_next.half = '0;
               st_next.sck = cfg.clock_polarity_select ^ cfg.clock_phase_select;
            end else if (cfg.enable && !cfg.master && st_reg.ss_prev && !nss_in) begin
               st_next.mode = scdp_pkg::ST_SLAVE;
               st_next.bits = '0;
               st_next.first = 1'b1;
               st_next.tail_run = 1'b0;
               if (!st_reg.tx_empty) begin
                  st_next.osh = st_reg.txb;
                  st_next.tx_empty = 1'b1;
               end
            end
         end
         scdp_pkg::ST_MASTER: begin
            if (half_end) begin
               st_next.half = half_inc;
               st_next.sck = cfg.clock_polarity_select
                  ^ (cfg.clock_phase_select ? !half_inc[0] : half_inc[0]);
               if (st_reg.half[0]) begin
                  // Last cycle of the bit: sample, then shift MSB first
                  st_next.ish = {st_reg.ish[6:0], miso_in};
                  st_next.osh = {st_reg.osh[6:0], 1'b0};
                  st_next.mosi = st_reg.osh[6];
               end
               if (st_reg.half == scdp_pkg::LAST_HALF) begin
                  st_next.mode = scdp_pkg::ST_IDLE;
                  st_next.rxb = {st_reg.ish[6:0], miso_in};
                  st_next.sck = cfg.clock_polarity_select;
                  st_next.flags.transfer_done_flag = 1'b1;
               end
            end
         end
         scdp_pkg::ST_SLAVE: begin
            if (nss_in) begin
               st_next.mode = scdp_pkg::ST_IDLE;
            end else begin
               if (sample_edge) begin
                  st_next.ish = {st_reg.ish[6:0], mosi_in};
                  st_next.bits = st_reg.bits + 4'h1;
                  if (st_reg.bits == scdp_pkg::LAST_BIT) begin
                     st_next.bits = '0;
                     st_next.rxb = {st_reg.ish[6:0], mosi_in};
                     st_next.flags.transfer_done_flag = 1'b1;
                     st_next.tail_run = cfg.clock_phase_select;
                     st_next.tail = '0;
                  end
               end
               if (shift_edge) begin
                  if (cfg.clock_phase_select && st_reg.first) begin
                     st_next.first = 1'b0;
                  end else begin
                     st_next.osh = {st_reg.osh[6:0], 1'b0};
                  end
               end
            end
         end
         default: st_next.mode = scdp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.mode <= scdp_pkg::ST_IDLE;
         st_reg.rate <= scdp_pkg::RATE_RST;
         st_reg.rxb <= scdp_pkg::DATA_RST;
         st_reg.tx_empty <= 1'b1;
         st_reg.ss_prev <= 1'b1;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign sfr_rdata = st_reg.rdata;
   assign flags = st_reg.flags;
   assign tx_buffer_empty_flag = st_reg.tx_empty;
   assign sck_out = st_reg.sck;
   assign sck_oe = cfg.enable && cfg.master;
   assign mosi_out = st_reg.mosi;
   assign mosi_oe = cfg.enable && cfg.master;
   assign miso_out = st_reg.miso;
   assign miso_oe = st_reg.miso_oe;
   assign nss_out = cfg.select_line_mode[0];
   assign nss_oe = cfg.enable && cfg.select_line_mode[1];

   // Cycles since the serial clock last moved
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hc_reg <= '0;
      end else if (clk_en) begin
         hc_reg <= (st_next.sck != st_reg.sck) ? 9'h000 : hc_reg + 9'h001;
      end
   end

   AST_HALF_LEN: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (st_reg.mode == scdp_pkg::ST_MASTER && st_reg.half >= 4'h2 && half_end
       && st_reg.half != scdp_pkg::LAST_HALF)
      |-> hc_reg == {1'b0, st_reg.rate})
      else $error("Master half period differs from divider setting");
   AST_READ_RX: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (sfr_req.rd && sfr_req.addr == scdp_pkg::ADDR_DATA) |=> sfr_rdata == $past(st_reg.rxb))
      else $error("Data read did not return receive buffer");
   AST_WR_LOAD: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (wr_data && st_reg.tx_empty) |=> (!tx_buffer_empty_flag && st_reg.txb == $past(sfr_req.wdata)))
      else $error("Data write did not fill transmit buffer");
   AST_WR_COLL: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (wr_data && !st_reg.tx_empty) |=> (flags.write_collision_flag && $stable(st_reg.txb)))
      else $error("Collision write changed buffer or left flag clear");
   AST_IDLE_POL: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (st_reg.mode == scdp_pkg::ST_IDLE && $stable(cfg.clock_polarity_select))
      |-> sck_out == cfg.clock_polarity_select)
      else $error("Idle serial clock not at polarity level");
   AST_SEL_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      ($fell(nss_in) && cfg.enable && !cfg.master && $stable(cfg)) |-> ##[0:3] miso_oe)
      else $error("Slave output not driven in time");
   AST_SEL_RELEASE: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      $rose(nss_in) |-> ##[0:3] !miso_oe)
      else $error("Slave output not released in time");
   AST_SHIFT_OUT: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (st_reg.mode == scdp_pkg::ST_SLAVE && !nss_in && shift_edge && !st_reg.tail_run
       && !(cfg.clock_phase_select && st_reg.first))
      |-> ##2 miso_out == $past(st_reg.osh[6], 2))
      else $error("Slave output not updated after shift edge");
   AST_TAIL: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (st_reg.mode == scdp_pkg::ST_SLAVE && !nss_in && cfg.clock_phase_select && sample_edge
       && st_reg.bits == scdp_pkg::LAST_BIT)
      |=> st_reg.tail_run [*5] ##1 !st_reg.tail_run)
      else $error("Phase-one tail reload mistimed");
   AST_M_DONE: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (st_reg.mode == scdp_pkg::ST_MASTER && half_end && st_reg.half == scdp_pkg::LAST_HALF)
      |=> (flags.transfer_done_flag && st_reg.mode == scdp_pkg::ST_IDLE
           && st_reg.rxb[0] == $past(miso_in)))
      else $error("Master transfer end not flagged or last bit lost");
   AST_MODE_FAULT: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
      (cfg.enable && cfg.master && cfg.select_line_mode == scdp_pkg::SEL_MULTI && !nss_in)
      |=> flags.mode_fault_flag)
      else $error("Mode fault not flagged");
endmodule

// *** hdl/scdp_pkg.sv ***
// Shared constants and types of the serial clock-rate and data port block
package scdp_pkg;
   // Register addresses and reset values
   localparam logic [7:0] ADDR_RATE = 8'ha2;
   localparam logic [7:0] ADDR_DATA = 8'ha3;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;
   // Select-line modes: 3-wire, 4-wire multi-master input, 4-wire single-master output
   localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
   localparam logic [1:0] SEL_MULTI = 2'h1;
   // Transfer shape
   localparam logic [3:0] LAST_HALF = 4'hf;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // Timing, in nanoseconds at a 50 ns core clock, and derived cycle counts
   localparam int CLK_NS = 50;
   localparam int SEZ_MAX_NS = 4 * CLK_NS;
   localparam int SEZ_CYC = SEZ_MAX_NS / CLK_NS;
   localparam int SLH_MIN_NS = 6 * CLK_NS;
   localparam int SLH_MAX_NS = 8 * CLK_NS;
   localparam int SLH_CYC = (SLH_MIN_NS + SLH_MAX_NS) / (2 * CLK_NS);
   // Tail count end: edge detect and output register add two cycles
   localparam logic [2:0] TAIL_LAST = 3'(SLH_CYC - 3);

   typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} scdp_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } scdp_sfr_req_t;

   typedef struct packed {
      logic enable;
      logic master;
      logic clock_polarity_select;
      logic clock_phase_select;
      logic [1:0] select_line_mode;
   } scdp_cfg_t;

   typedef struct packed {
      logic transfer_done_flag;
      logic write_collision_flag;
      logic mode_fault_flag;
   } scdp_flags_t;

   typedef struct packed {
      logic [7:0] cnt;
   } scdp_div_state_t;

   typedef struct packed {
      scdp_mode_t mode;
      logic [7:0] rate;
      logic [7:0] txb;
      logic tx_empty;
      logic [7:0] rxb;
      logic [7:0] osh;
      logic [7:0] ish;
      logic [3:0] half;
      logic [3:0] bits;
      logic sck;
      logic mosi;
      logic miso;
      logic miso_oe;
      logic ss_prev;
      logic s_prev;
      logic first;
      logic tail_run;
      logic [2:0] tail;
      scdp_flags_t flags;
      logic [7:0] rdata;
   } scdp_core_state_t;
endpackage

// *** hdl/scdp_half_timer.sv ***
// Half-period timer that paces the master serial clock
`timescale 1ns/1ps
module scdp_half_timer #(
   parameter int DIV_W = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic run,
   input wire logic [DIV_W-1:0] divisor,
   output logic half_end
);
   scdp_pkg::scdp_div_state_t st_reg;
   scdp_pkg::scdp_div_state_t st_next;

   // Each half period lasts divisor + 1 core clocks
   always_comb begin
      st_next = st_reg;
      if (!run || st_reg.cnt == divisor) begin
         st_next.cnt = '0;
      end else begin
         st_next.cnt = st_reg.cnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign half_end = run && (st_reg.cnt == divisor);
endmodule

// *** tb/scdp_partner.sv ***
// Behavioural external SPI slave for master-mode transfers
`timescale 1ns/1ps
module scdp_partner (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pol,
   input wire logic pha,
   input wire logic sck,
   input wire logic mosi,
   input wire logic load,
   input wire logic [7:0] load_byte,
   output logic miso,
   output logic [7:0] got
);
   logic prev;
   logic [7:0] sh;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev <= 1'b0;
         sh <= 8'h00;
         got <= 8'h00;
         miso <= 1'b0;
      end else begin
         prev <= sck;
         if (load) begin
            sh <= load_byte;
            if (!pha) miso <= load_byte[7];
         end else if (sck != prev) begin
            // Leading edge samples for phase 0, trailing edge for phase 1
            if ((sck != pol) == !pha) begin
               got <= {got[6:0], mosi};
            end else if (!pha) begin
               miso <= sh[6];
               sh <= {sh[6:0], 1'b0};
            end else begin
               miso <= sh[7];
               sh <= {sh[6:0], 1'b0};
            end
         end
      end
   end
endmodule

// *** tb/scdp_core_tb.sv ***
// Self-checking bench of the serial clock-rate and data port
`timescale 1ns/1ps
module scdp_core_tb;
   typedef struct packed {
      logic [7:0] rate;
      logic pol;
      logic pha;
      logic [7:0] tx;
      logic [7:0] rx;
   } scdp_row_t;
   localparam scdp_row_t ROWS [4] = '{'{8'h02, 1'b0, 1'b0, 8'ha5, 8'h3c},
      '{8'h03, 1'b1, 1'b0, 8'h5a, 8'hc3}, '{8'h04, 1'b0, 1'b1, 8'h81, 8'h7e},
      '{8'hff, 1'b1, 1'b1, 8'hf0, 8'h0f}};
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic sck_in = 1'b0;
   logic mosi_in = 1'b0;
   logic nss_in = 1'b1;
   logic miso_in;
   logic load = 1'b0;
   logic tog_clr = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] rx_byte = 8'h00;
   logic [7:0] got;
   logic [7:0] sfr_rdata;
   logic tx_buffer_empty_flag, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic nss_out, nss_oe, sck_prev;
   scdp_pkg::scdp_sfr_req_t sfr_req = '0;
   scdp_pkg::scdp_cfg_t cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 2'h2};
   scdp_pkg::scdp_flags_t flag_clr = '0;
   scdp_pkg::scdp_flags_t flags;
   int error_cnt = 0;
   int total_checks = 0;
   int tog = 0;
   int gap = 0;
   int run = 0;
   always #25 core_clk = ~core_clk;
   scdp_core dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .cfg(cfg), .flag_clr(flag_clr), .flags(flags),
      .tx_buffer_empty_flag(tx_buffer_empty_flag), .sck_in(sck_in), .mosi_in(mosi_in),
      .miso_in(miso_in), .nss_in(nss_in), .sck_out(sck_out), .sck_oe(sck_oe),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
      .nss_out(nss_out), .nss_oe(nss_oe));
   scdp_partner slv (.core_clk(core_clk), .reset_n(reset_n), .pol(cfg.clock_polarity_select),
      .pha(cfg.clock_phase_select), .sck(sck_out), .mosi(mosi_out), .load(load),
      .load_byte(rx_byte), .miso(miso_in), .got(got));
   // Counts clock toggles and the length of the last held level
   always @(posedge core_clk) begin
      sck_prev <= sck_out;
      if (tog_clr) tog <= 0;
      else if (sck_out !== sck_prev) tog <= tog + 1;
      if (sck_out !== sck_prev) begin
         gap <= run;
         run <= 1;
      end else run <= run + 1;
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk) sfr_req <= '{a, 1'b1, 1'b0, d};
      @(posedge core_clk) sfr_req.wr <= 1'b0;
   endtask
   task automatic sfr_rd(logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge core_clk) sfr_req.rd <= 1'b0;
      @(negedge core_clk) v = sfr_rdata;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (flags.transfer_done_flag !== 1'b1 && n < 6000) begin
         @(negedge core_clk);
         n++;
      end
      chk("done_flag", 16'h1, {15'h0, flags.transfer_done_flag});
   endtask
   task automatic clr();
      repeat (2) @(negedge core_clk);
      @(posedge core_clk) flag_clr <= 3'h7;
      @(posedge core_clk) flag_clr <= 3'h0;
      @(negedge core_clk) chk("flags_cleared", 16'h0, {13'h0, flags});
   endtask
   task automatic xfer(scdp_row_t r);
      logic [7:0] v;
      @(posedge core_clk) cfg.clock_polarity_select <= r.pol;
      cfg.clock_phase_select <= r.pha;
      // Let the idle clock settle at the new level before the slave loads
      repeat (2) @(posedge core_clk);
      rx_byte <= r.rx;
      load <= 1'b1;
      @(posedge core_clk) load <= 1'b0;
      sfr_wr(scdp_pkg::ADDR_RATE, r.rate);
      @(posedge core_clk) tog_clr <= 1'b1;
      @(posedge core_clk) tog_clr <= 1'b0;
      sfr_wr(scdp_pkg::ADDR_DATA, r.tx);
      wait_done();
      @(negedge core_clk) chk("toggles", 16'h10, 16'(tog));
      chk("half_len", 16'(r.rate) + 16'h1, 16'(gap));
      chk("sck_idle", {15'h0, r.pol}, {15'h0, sck_out});
      chk("master_oe", 16'he, {12'h0, sck_oe, mosi_oe, nss_oe, nss_out});
      chk("slave_got", {8'h0, r.tx}, {8'h0, got});
      sfr_rd(scdp_pkg::ADDR_DATA, v);
      chk("rx_read", {8'h0, r.rx}, {8'h0, v});
      clr();
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      logic [7:0] v;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) xfer(ROWS[i]);
      // Third write lands while one byte shifts and another waits
      @(posedge core_clk) cfg.clock_phase_select <= 1'b0;
      cfg.clock_polarity_select <= 1'b0;
      sfr_wr(scdp_pkg::ADDR_RATE, 8'h00);
      sfr_wr(scdp_pkg::ADDR_DATA, 8'h11);
      sfr_wr(scdp_pkg::ADDR_DATA, 8'h22);
      @(negedge core_clk) chk("tx_full", 16'h0, {15'h0, tx_buffer_empty_flag});
      sfr_wr(scdp_pkg::ADDR_DATA, 8'h33);
      @(negedge core_clk) chk("write_collision_flag", 16'h1, {15'h0, flags.write_collision_flag});
      wait_done();
      clr();
      wait_done();
      @(negedge core_clk) chk("kept_byte", 16'h22, {8'h0, got});
      chk("half_len0", 16'h1, 16'(gap));
      clr();
      @(posedge core_clk) cfg.select_line_mode <= scdp_pkg::SEL_MULTI;
      nss_in <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk("mode_fault", 16'h1, {15'h0, flags.mode_fault_flag});
      @(posedge core_clk) nss_in <= 1'b1;
      cfg.master <= 1'b0;
      clr();
      sfr_wr(scdp_pkg::ADDR_RATE, 8'h07);
      sfr_wr(scdp_pkg::ADDR_DATA, 8'hc3);
      @(negedge core_clk) chk("slave_sck_oe", 16'h0, {13'h0, sck_oe, mosi_oe, nss_oe});
      @(posedge core_clk) nss_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk) chk("miso_oe_on", 16'h1, {15'h0, miso_oe});
      v = {7'h0, miso_out};
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk) mosi_in <= 1'(8'h96 >> (7 - i));
         repeat (3) @(posedge core_clk);
         sck_in <= 1'b1;
         repeat (5) @(posedge core_clk);
         sck_in <= 1'b0;
         repeat (4) @(posedge core_clk);
         @(negedge core_clk) if (i < 7) v = {v[6:0], miso_out};
      end
      repeat (2) @(posedge core_clk);
      nss_in <= 1'b1;
      mosi_in <= ~mosi_in;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk) chk("miso_oe_off", 16'h0, {15'h0, miso_oe});
      chk("miso_byte", 16'hc3, {8'h0, v});
      chk("slave_done", 16'h1, {15'h0, flags.transfer_done_flag});
      sfr_rd(scdp_pkg::ADDR_DATA, v);
      chk("slave_rx", 16'h96, {8'h0, v});
      // Phase-one slave: first leading edge keeps bit 7, empty buffer at the tail
      @(posedge core_clk) cfg.clock_phase_select <= 1'b1;
      clr();
      sfr_wr(scdp_pkg::ADDR_DATA, 8'ha5);
      @(posedge core_clk) nss_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk) sck_in <= 1'b1;
         mosi_in <= 1'(8'h3c >> (7 - i));
         repeat (5) @(posedge core_clk);
         sck_in <= 1'b0;
         repeat (5) @(posedge core_clk);
         @(negedge core_clk) v = {v[6:0], miso_out};
      end
      chk("tail_hold", 16'h1, {15'h0, miso_out});
      repeat (3) @(negedge core_clk);
      chk("tail_reload", 16'h0, {15'h0, miso_out});
      @(posedge core_clk) nss_in <= 1'b1;
      chk("miso_byte1", 16'ha5, {8'h0, v});
      chk("slave_done1", 16'h1, {15'h0, flags.transfer_done_flag});
      sfr_rd(scdp_pkg::ADDR_DATA, v);
      chk("slave_rx1", 16'h3c, {8'h0, v});
      // A write while the clock enable is low must leave the rate untouched
      @(posedge core_clk) clk_en <= 1'b0;
      sfr_wr(scdp_pkg::ADDR_RATE, 8'h42);
      @(posedge core_clk) clk_en <= 1'b1;
      sfr_rd(scdp_pkg::ADDR_RATE, v);
      chk("frozen_rate", 16'h07, {8'h0, v});
      // Reset in mid-run returns registers and flags to their reset values
      @(posedge core_clk) reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      sfr_rd(scdp_pkg::ADDR_RATE, v);
      chk("rate_reset", {8'h0, scdp_pkg::RATE_RST}, {8'h0, v});
      sfr_rd(scdp_pkg::ADDR_DATA, v);
      chk("data_reset", {8'h0, scdp_pkg::DATA_RST}, {8'h0, v});
      sfr_rd(8'h55, v);
      chk("unmapped", {8'h0, scdp_pkg::READ_NONE}, {8'h0, v});
      chk("reset_flags", 16'h1, {12'h0, flags, tx_buffer_empty_flag});
      report_and_stop();
   end
endmodule
